/* File: dac_cfg_pkg.sv */
// constants for the protect, interface, scratch memory and broadcast register group
// assumes a 16-bit register port with 8-bit addresses decoded by the serial front end
package dac_cfg_pkg;
  localparam logic [7:0] protect_mode_config_addr = 8'h25;
  localparam logic [7:0] serial_interface_config_addr = 8'h26;
  localparam logic [7:0] scratch_mem_pointer_addr = 8'h2b;
  localparam logic [7:0] scratch_mem_data_addr = 8'h2c;
  localparam logic [7:0] all_channel_code_addr = 8'h50;
  localparam logic [15:0] reg_reset = 16'h0000;
  localparam int protect_lsb = 8;
  localparam int timeout_bit = 12;
  localparam int quick_readout_bit = 2;
  localparam int readout_enable_bit = 0;
  localparam int code_lsb = 4;
  localparam logic [3:0] pin_fn_protect = 4'h5;
  localparam logic [1:0] act_hiz = 2'h0;
  localparam logic [1:0] act_nvm = 2'h1;
  localparam logic [1:0] act_margin_low = 2'h2;
  localparam logic [1:0] act_margin_high = 2'h3;
  typedef enum logic [1:0] {prot_idle, prot_slew, prot_powerdown} prot_state_e;
endpackage : dac_cfg_pkg

/* File: dac_mode_iface_sram_broadcast_regs.sv */
// register group: protect action, interface options, scratch memory access, broadcast code
// assumes the serial front end presents single-cycle write and read strobes on clock,
// and that the output slewing engine reports slew completion with slew_done.
// Operation
// - protect action 00 powers down to high impedance at once, 01 loads the stored code then powers down.
// - protect action 10 or 11 slews to the margin-low or margin-high code then powers down.
// - bit 12 of the interface register enables the bus timeout, cleared at reset.
// - bit 2 of the interface register selects fast serial-out timing.
// - the shared pin carries read data only while bit 0 of the interface register is set.
// - writing the pointer bits 7-0 selects the scratch location for the next data access.
// - each data-port write advances the pointer by one.
// - a data-port write stores at the pointer, a read returns the word at the pointer.
// - the 10-bit broadcast code comes from bits 15-6 of the left-aligned field, bits 3-0 ignored.
// - the broadcast code is unsigned straight binary with its msb at bit 15.
// - a broadcast write updates only channels whose group write enable is set.
// - with the pin function set to protect, a falling edge on the pin fires the protect action.
module dac_mode_iface_sram_broadcast_regs #(
  parameter int channels = 3,
  parameter int depth = 256
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  output logic reg_hit,
  input wire logic [3:0] pin_input_function,
  input wire logic shared_io_readout_pin_in,
  input wire logic spi_read_bit,
  output logic shared_io_readout_pin_out,
  output logic shared_io_readout_pin_oe,
  output logic bus_timeout_enable,
  output logic quick_readout_enable,
  input wire logic [channels-1:0] channel_group_write_enable,
  output logic [channels-1:0] channel_code_load,
  output logic [9:0] all_channel_code,
  input wire logic slew_done,
  output logic protect_busy,
  output logic [1:0] protect_action,
  output logic load_nvm_code,
  output logic slew_start,
  output logic slew_to_high,
  output logic powerdown_hiz
);
  logic [1:0] protect_r;
  logic timeout_r;
  logic quick_r;
  logic readout_en_r;
  logic [7:0] pointer_r;
  logic [15:0] code_word_r;
  logic [15:0] mem [depth];
  logic [15:0] mem_rd_r;
  logic pin_s1_r, pin_s2_r, pin_prev_r;
  logic protect_fire;
  dac_cfg_pkg::prot_state_e state_r;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    return reg_write && a == b;
  endfunction : hit

  always_ff @(posedge clock) begin
    if (rst) begin
      protect_r <= dac_cfg_pkg::reg_reset[9:8];
      timeout_r <= 1'b0;
      quick_r <= 1'b0;
      readout_en_r <= 1'b0;
    end else if (hit(reg_addr, dac_cfg_pkg::protect_mode_config_addr)) begin
      protect_r <= reg_wdata[dac_cfg_pkg::protect_lsb +: 2]; // reserved bits not stored
    end else if (hit(reg_addr, dac_cfg_pkg::serial_interface_config_addr)) begin
      timeout_r <= reg_wdata[dac_cfg_pkg::timeout_bit];
      quick_r <= reg_wdata[dac_cfg_pkg::quick_readout_bit];
      readout_en_r <= reg_wdata[dac_cfg_pkg::readout_enable_bit];
    end
  end

  // pointer: explicit write beats the post-increment, they cannot coincide anyway
  always_ff @(posedge clock) begin
    if (rst) begin
      pointer_r <= 8'h00;
    end else if (hit(reg_addr, dac_cfg_pkg::scratch_mem_pointer_addr)) begin
      pointer_r <= reg_wdata[7:0];
    end else if (hit(reg_addr, dac_cfg_pkg::scratch_mem_data_addr)) begin
      pointer_r <= pointer_r + 8'h01;
    end
  end

  // memory contents are not reset: this is a plain ram
  always_ff @(posedge clock) begin
    if (hit(reg_addr, dac_cfg_pkg::scratch_mem_data_addr)) begin
      mem[pointer_r] <= reg_wdata;
    end
    mem_rd_r <= mem[pointer_r];
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      code_word_r <= 16'h0000;
      channel_code_load <= '0;
    end else begin
      channel_code_load <= '0;
      if (hit(reg_addr, dac_cfg_pkg::all_channel_code_addr)) begin
        code_word_r <= {reg_wdata[15:4], 4'h0};
        channel_code_load <= channel_group_write_enable;
      end
    end
  end
  assign all_channel_code = code_word_r[15:6]; // unsigned, msb at bit 15

  // read mux; memory word is prefetched each cycle so reads answer combinationally
  always_comb begin
    reg_rdata = 16'h0000;
    reg_hit = 1'b1;
    if (reg_addr == dac_cfg_pkg::protect_mode_config_addr) begin
      reg_rdata = {6'h00, protect_r, 8'h00};
    end else if (reg_addr == dac_cfg_pkg::serial_interface_config_addr) begin
      reg_rdata = {3'h0, timeout_r, 9'h000, quick_r, 1'b0, readout_en_r};
    end else if (reg_addr == dac_cfg_pkg::scratch_mem_pointer_addr) begin
      reg_rdata = {8'h00, pointer_r};
    end else if (reg_addr == dac_cfg_pkg::scratch_mem_data_addr) begin
      reg_rdata = mem_rd_r;
    end else if (reg_addr == dac_cfg_pkg::all_channel_code_addr) begin
      reg_rdata = code_word_r;
    end else begin
      reg_hit = 1'b0;
    end
  end

  assign bus_timeout_enable = timeout_r;
  assign quick_readout_enable = quick_r;
  assign shared_io_readout_pin_oe = readout_en_r;
  assign shared_io_readout_pin_out = readout_en_r & spi_read_bit;

  // pin is asynchronous: two stages before the edge detector
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
      pin_prev_r <= 1'b1;
    end else begin
      pin_s1_r <= shared_io_readout_pin_in;
      pin_s2_r <= pin_s1_r;
      pin_prev_r <= pin_s2_r;
    end
  end
  assign protect_fire = (pin_input_function == dac_cfg_pkg::pin_fn_protect) && pin_prev_r && !pin_s2_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= dac_cfg_pkg::prot_idle;
      load_nvm_code <= 1'b0;
      slew_start <= 1'b0;
      slew_to_high <= 1'b0;
      powerdown_hiz <= 1'b0;
      protect_action <= dac_cfg_pkg::act_hiz;
    end else begin
      load_nvm_code <= 1'b0;
      slew_start <= 1'b0;
      case (state_r)
        dac_cfg_pkg::prot_idle: begin
          if (protect_fire) begin
            protect_action <= protect_r;
            case (protect_r)
              dac_cfg_pkg::act_hiz: begin
                powerdown_hiz <= 1'b1;
                state_r <= dac_cfg_pkg::prot_powerdown;
              end
              dac_cfg_pkg::act_nvm: begin
                load_nvm_code <= 1'b1; // jump, then power down next cycle
                state_r <= dac_cfg_pkg::prot_powerdown;
              end
              default: begin
                slew_start <= 1'b1;
                slew_to_high <= (protect_r == dac_cfg_pkg::act_margin_high);
                state_r <= dac_cfg_pkg::prot_slew;
              end
            endcase
          end
        end
        dac_cfg_pkg::prot_slew: begin
          if (slew_done) begin
            state_r <= dac_cfg_pkg::prot_powerdown;
          end
        end
        default: begin
          powerdown_hiz <= 1'b1; // held until reset
        end
      endcase
    end
  end
  assign protect_busy = (state_r != dac_cfg_pkg::prot_idle);

  timeout_follow_a: assert property (@(posedge clock) disable iff (rst)
    $rose(reg_write && reg_addr == 8'h26) |-> ##1 bus_timeout_enable == $past(reg_wdata[12]))
    else $error("timeout enable not taken from bit 12");
  quick_follow_a: assert property (@(posedge clock) disable iff (rst)
    (reg_write && reg_addr == 8'h26) |=> quick_readout_enable == $past(reg_wdata[2]))
    else $error("fast readout not taken from bit 2");
  pin_gate_a: assert property (@(posedge clock) disable iff (rst)
    !shared_io_readout_pin_oe |-> !shared_io_readout_pin_out)
    else $error("pin driven while readout disabled");
  pointer_load_a: assert property (@(posedge clock) disable iff (rst)
    (reg_write && reg_addr == 8'h2b) |=> pointer_r == $past(reg_wdata[7:0]))
    else $error("pointer not loaded");
  pointer_step_a: assert property (@(posedge clock) disable iff (rst)
    (reg_write && reg_addr == 8'h2c) |=> pointer_r == $past(pointer_r) + 8'h01)
    else $error("pointer not advanced");
  mem_readback_a: assert property (@(posedge clock) disable iff (rst)
    (reg_write && reg_addr == 8'h2c) |=> mem[$past(pointer_r)] == $past(reg_wdata))
    else $error("stored word mismatch");
  code_align_a: assert property (@(posedge clock) disable iff (rst)
    (reg_write && reg_addr == 8'h50) |=> all_channel_code == $past(reg_wdata[15:6]))
    else $error("broadcast code misaligned");
  group_load_a: assert property (@(posedge clock) disable iff (rst)
    channel_code_load != '0 |-> (channel_code_load & ~$past(channel_group_write_enable)) == '0)
    else $error("disabled channel loaded");
  fire_hiz_a: assert property (@(posedge clock) disable iff (rst)
    (protect_fire && state_r == dac_cfg_pkg::prot_idle && protect_r == 2'h0) |=> powerdown_hiz)
    else $error("direct power down missing");
  fire_nvm_a: assert property (@(posedge clock) disable iff (rst)
    (protect_fire && state_r == dac_cfg_pkg::prot_idle && protect_r == 2'h1) |=> load_nvm_code ##1 powerdown_hiz)
    else $error("nvm jump sequence wrong");
  fire_slew_a: assert property (@(posedge clock) disable iff (rst)
    (protect_fire && state_r == dac_cfg_pkg::prot_idle && protect_r[1]) |=> slew_start && slew_to_high == $past(protect_r[0]))
    else $error("margin slew not started");
  edge_only_a: assert property (@(posedge clock) disable iff (rst)
    (state_r == dac_cfg_pkg::prot_idle && !protect_fire) |=> state_r == dac_cfg_pkg::prot_idle)
    else $error("protect entered without falling edge");
  protect_rst_a: assert property (@(posedge clock) $fell(rst) |-> protect_r == 2'h0)
    else $error("protect action not reset");

  cover_hiz_c: cover property (@(posedge clock) disable iff (rst) powerdown_hiz && protect_action == 2'h0);
  cover_slew_c: cover property (@(posedge clock) disable iff (rst) state_r == dac_cfg_pkg::prot_slew ##1 slew_done);
  cover_burst_c: cover property (@(posedge clock) disable iff (rst)
    (reg_write && reg_addr == 8'h2c) ##1 (reg_write && reg_addr == 8'h2c));
  cover_bcast_c: cover property (@(posedge clock) disable iff (rst) channel_code_load != '0);
endmodule : dac_mode_iface_sram_broadcast_regs

/* File: cfg_host.sv */
// register bus host model: write strobe held until the next read or idle, combinational read data
// assumes each task is entered just after a rising clock edge and returns just after one
module cfg_host (
  input wire logic clock,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_write,
  output logic reg_read,
  input wire logic [15:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_read <= 1'b0;
    reg_write <= 1'b1;
    if (a == dac_cfg_pkg::protect_mode_config_addr) reg_wdata <= d & 16'h031f;
    else if (a == dac_cfg_pkg::serial_interface_config_addr) reg_wdata <= d & 16'hfeff;
    else reg_wdata <= d;
    @(posedge clock);
  endtask : wr
  // released data lines toggle so a stale word never looks valid
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    reg_wdata <= ~reg_wdata;
    // the combinational answer is taken at the rising edge that closes the request
    @(posedge clock);
    d = reg_rdata;
  endtask : rd
  task automatic idle();
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    reg_wdata <= ~reg_wdata;
    @(posedge clock);
  endtask : idle
endmodule : cfg_host

/* File: dac_mode_iface_sram_broadcast_regs_tb.sv */
// self-checking bench for the protect, interface, scratch memory and broadcast register group
// assumes cfg_host drives the register port; the bench plays the slew engine and the pin
module dac_mode_iface_sram_broadcast_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd_v, v;
  logic reg_write, reg_read, reg_hit, shared_io_readout_pin_out, shared_io_readout_pin_oe;
  logic shared_io_readout_pin_in = 1'b1;
  logic spi_read_bit = 1'b0;
  logic slew_done = 1'b0;
  logic bus_timeout_enable, quick_readout_enable, protect_busy, load_nvm_code, slew_start, slew_to_high, powerdown_hiz;
  logic [3:0] pin_input_function = 4'h0;
  logic [2:0] channel_group_write_enable = 3'h0;
  logic [2:0] channel_code_load;
  logic [9:0] all_channel_code;
  logic [1:0] protect_action;
  logic [15:0] mem[256];
  logic [7:0] regs[4] = '{8'h25, 8'h26, 8'h2b, 8'h50};
  int n_errors = 0;
  int tests_run = 0;
  int k, dly, nvm, st, hi, p;
  always #50 clock = ~clock;
  dac_mode_iface_sram_broadcast_regs #(.channels(3), .depth(256)) dut (.clock, .rst, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .reg_hit, .pin_input_function, .shared_io_readout_pin_in, .spi_read_bit,
    .shared_io_readout_pin_out, .shared_io_readout_pin_oe, .bus_timeout_enable, .quick_readout_enable,
    .channel_group_write_enable, .channel_code_load, .all_channel_code, .slew_done, .protect_busy,
    .protect_action, .load_nvm_code, .slew_start, .slew_to_high, .powerdown_hiz);
  cfg_host host (.clock, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata);
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [15:0] exp);
    host.rd(a, rd_v);
    chk(what, exp, rd_v);
  endtask : rd_chk
  task automatic do_reset();
    rst <= 1'b1;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
  endtask : do_reset
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  initial begin
    k = $urandom(31884);
    do_reset();
    foreach (regs[i]) rd_chk("reset value", regs[i], 16'h0000);
    chk("mapped hit", 16'h0001, 16'(reg_hit));
    rd_chk("unmapped data", 8'h30, 16'h0000);
    chk("unmapped hit", 16'h0000, 16'(reg_hit));
    $display("test reset done");
    repeat (4) begin
      v = 16'($urandom);
      spi_read_bit <= v[15];
      host.wr(8'h26, v);
      rd_chk("interface", 8'h26, v & 16'h1005);
      chk("timeout", 16'(v[12]), 16'(bus_timeout_enable));
      chk("fast readout", 16'(v[2]), 16'(quick_readout_enable));
      chk("pin enable", 16'(v[0]), 16'(shared_io_readout_pin_oe));
      chk("pin drive", 16'(v[0] & v[15]), 16'(shared_io_readout_pin_out));
      v = 16'($urandom);
      host.wr(8'h25, v);
      rd_chk("protect mode", 8'h25, v & 16'h0300);
    end
    $display("test interface done");
    v = 16'($urandom);
    host.wr(8'h2b, {v[15:8], 8'hfe});
    p = 254;
    repeat (3) begin
      v = 16'($urandom);
      mem[p] = v;
      host.wr(8'h2c, v);
      p = (p + 1) % 256;
    end
    host.idle();
    host.idle();
    rd_chk("pointer", 8'h2b, 16'(p));
    for (int i = 254; i < 257; i++) begin
      host.wr(8'h2b, 16'(i % 256));
      host.idle();
      host.idle();
      rd_chk("scratch word", 8'h2c, mem[i % 256]);
      rd_chk("pointer after read", 8'h2b, 16'(i % 256));
    end
    $display("test scratch done");
    repeat (3) begin
      v = 16'($urandom);
      channel_group_write_enable <= 3'($urandom);
      host.wr(8'h50, 16'($urandom));
      host.wr(8'h50, v);
      // strobe drops at the next rising edge, so the load pulse, held high over the second write and the idle cycle, is seen once, mid-cycle
      fork
        host.idle();
        begin
          @(negedge clock);
          chk("code", 16'(v[15:6]), 16'(all_channel_code));
          chk("load", 16'(channel_group_write_enable), 16'(channel_code_load));
        end
      join
      rd_chk("broadcast", 8'h50, v & 16'hfff0);
      chk("load end", 16'h0000, 16'(channel_code_load));
    end
    $display("test broadcast done");
    for (int a = 0; a < 4; a++) begin
      do_reset();
      pin_input_function <= 4'h0;
      host.wr(8'h25, 16'(a) << 8);
      shared_io_readout_pin_in <= 1'b0;
      repeat (5) @(posedge clock);
      chk("other function", 16'h0000, 16'(powerdown_hiz));
      shared_io_readout_pin_in <= 1'b1;
      pin_input_function <= 4'h5;
      repeat (5) @(posedge clock);
      chk("rising edge", 16'h0000, 16'(powerdown_hiz));
      chk("idle busy", 16'h0000, 16'(protect_busy));
      shared_io_readout_pin_in <= 1'b0;
      nvm = 0;
      st = 0;
      hi = 0;
      dly = 1000;
      for (k = 0; k < 40 && powerdown_hiz !== 1'b1; k++) begin
        @(posedge clock);
        if (load_nvm_code === 1'b1) nvm++;
        if (slew_start === 1'b1) begin
          st++;
          hi = int'(slew_to_high);
          dly = k + 1 + int'($urandom % 5);
        end
        slew_done <= (k == dly);
      end
      chk("power down", 16'h0001, 16'(powerdown_hiz));
      chk("busy", 16'h0001, 16'(protect_busy));
      chk("action", 16'(a), 16'(protect_action));
      chk("code loads", 16'(a == 1), 16'(nvm));
      chk("slew starts", 16'(a >> 1), 16'(st));
      if (a > 1) chk("slew target", 16'(a & 1), 16'(hi));
      if (a < 2) chk("quick power down", 16'h0001, 16'(k < 6));
    end
    $display("test protect done");
    complete_run();
  end
  initial begin
    #2000000;
    n_errors++;
    complete_run();
  end
endmodule : dac_mode_iface_sram_broadcast_regs_tb
